// ==== rtl/ddr_link_pkg.sv ====
// shared constants, command codes and state encodings for both link ends
// assumes a controller that divides its clock by four to make the link clock
package ddr_link_pkg;

  // array organisation
  localparam int NUM_BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 13;
  localparam int ROW_W = 14;
  localparam int AUTO_PRECHARGE_ADDRESS_BIT = 10;
  localparam int ROWS_STD = 8192;
  localparam int ROWS_REDUCED = 16384;
  localparam int COLS_X16 = 1024;
  localparam int COLS_X32 = 512;
  localparam int COLS_REDUCED = 256;

  // link timing in link clock cycles; CK_DIV in clock_i cycles per link clock
  localparam int CAS_LATENCY = 2;
  localparam int WRITE_LATENCY = 1;
  localparam int CK_DIV = 4;

  // reset values
  localparam logic [3:0] CMD_PINS_IDLE = 4'h7;
  localparam logic RESET_CKE = 1'b1;

  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_LMR = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_BST = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DESEL = 4'h8
  } cmd_type;

  typedef enum logic [3:0] {
    PWR_ON = 4'h1,
    PWR_PRE_PD = 4'h2,
    PWR_ACT_PD = 4'h4,
    PWR_SELF = 4'h8
  } power_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ = 3'h4
  } ctl_state_type;

  function automatic cmd_type decode_cmd(input logic [3:0] pins);
    if (pins[3]) begin
      return CMD_DESEL;
    end
    return cmd_type'(pins);
  endfunction

  function automatic int col_count(input int bytes, input bit reduced);
    if (bytes == 2) begin
      return COLS_X16;
    end
    return reduced ? COLS_REDUCED : COLS_X32;
  endfunction

  function automatic int row_count(input bit reduced);
    return reduced ? ROWS_REDUCED : ROWS_STD;
  endfunction

endpackage

// ==== rtl/ddr_link_if.sv ====
// pins between the memory controller end and the memory end
// assumes each end drives only its own output and enable copies
`timescale 1ns/100ps
interface ddr_link_if #(
  parameter int DQ_BYTES = 2
);
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [ddr_link_pkg::BA_W-1:0] ba;
  logic [ddr_link_pkg::ADDR_W-1:0] addr;
  logic optional_row_bit_ball;
  logic [DQ_BYTES-1:0] dm;
  logic [8*DQ_BYTES-1:0] dq_ctl_o;
  logic dq_ctl_oe;
  logic [8*DQ_BYTES-1:0] dq_mem_o;
  logic dq_mem_oe;
  logic [DQ_BYTES-1:0] dqs_ctl_o;
  logic dqs_ctl_oe;
  logic [DQ_BYTES-1:0] dqs_mem_o;
  logic dqs_mem_oe;
  logic [8*DQ_BYTES-1:0] dq;
  logic [DQ_BYTES-1:0] dqs;

  // bus level from the enables; idle bus reads low
  assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
  assign dqs = dqs_mem_oe ? dqs_mem_o : (dqs_ctl_oe ? dqs_ctl_o : '0);

  modport ctl_end (
    output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, optional_row_bit_ball, dm,
    output dq_ctl_o, dq_ctl_oe, dqs_ctl_o, dqs_ctl_oe,
    input dq, dqs
  );

  modport mem_end (
    input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, optional_row_bit_ball, dm,
    input dq, dqs,
    output dq_mem_o, dq_mem_oe, dqs_mem_o, dqs_mem_oe
  );
endinterface

// ==== rtl/ddr_ctl_end.sv ====
// controller end: makes the link clock, issues commands, moves burst data
// assumes user requests come from logic on clock_i; one request at a time
`timescale 1ns/100ps
module ddr_ctl_end #(
  parameter int DQ_BYTES = 2,
  parameter bit REDUCED_PAGE = 1'b0,
  parameter int CAS_LAT = ddr_link_pkg::CAS_LATENCY
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // link
  ddr_link_if.ctl_end link,
  // request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire ddr_link_pkg::cmd_type req_op_i,
  input wire logic [ddr_link_pkg::BA_W-1:0] req_bank_i,
  input wire logic [ddr_link_pkg::ROW_W-1:0] req_addr_i,
  input wire logic [16*DQ_BYTES-1:0] req_wdata_i,
  input wire logic [2*DQ_BYTES-1:0] req_wmask_i,
  input wire logic cke_i,
  // read answer
  output logic rsp_valid_o,
  output logic [16*DQ_BYTES-1:0] rsp_rdata_o
);
  localparam int W = 8 * DQ_BYTES;

  if (!(DQ_BYTES == 2 || DQ_BYTES == 4) || (REDUCED_PAGE && DQ_BYTES != 4)
      || CAS_LAT < 1 || CAS_LAT > 14 || ddr_link_pkg::CK_DIV != 4) begin : g_bad_cfg
    $error("ddr_ctl_end: unsupported configuration");
  end

  typedef struct packed {
    logic [1:0] ph;
    logic ck;
    logic cke;
    logic [3:0] cmd;
    logic [ddr_link_pkg::BA_W-1:0] ba;
    logic [ddr_link_pkg::ADDR_W-1:0] a;
    logic a13;
    logic [DQ_BYTES-1:0] dm;
    logic [W-1:0] dq;
    logic dq_oe;
    logic dqs;
    ddr_link_pkg::ctl_state_type st;
    logic [3:0] cnt;
    logic got0;
    logic [2*W-1:0] wdata;
    logic [2*DQ_BYTES-1:0] wmask;
    logic [2*W-1:0] rdata;
    logic rsp_valid;
    logic ready;
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ctl_state_struct_type;

  localparam ctl_state_struct_type RST = '{st: ddr_link_pkg::ST_IDLE,
    cmd: ddr_link_pkg::CMD_PINS_IDLE, cke: ddr_link_pkg::RESET_CKE, default: '0};

  ctl_state_struct_type s_q;
  ctl_state_struct_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.ph = s_q.ph + 2'h1;
    // ck high in phases 0 and 1; rising edge on the ph 3 to 0 step
    s_d.ck = ~s_d.ph[1];
    s_d.s1 = link.dq;
    s_d.s2 = s_q.s1;
    s_d.rsp_valid = 1'b0;
    if (s_q.ph == 2'h3 && s_q.cnt != 4'h0) begin
      s_d.cnt = s_q.cnt - 4'h1;
    end
    // commands change on the link falling edge, stable at the rising one
    if (s_q.ph == 2'h1) begin
      s_d.cmd = ddr_link_pkg::CMD_NOP;
      s_d.cke = cke_i;
    end
    case (s_q.st)
      ddr_link_pkg::ST_IDLE: begin
        if (req_valid_i && s_q.ready) begin
          s_d.cmd = req_op_i;
          s_d.ba = req_bank_i;
          s_d.a = req_addr_i[ddr_link_pkg::ADDR_W-1:0];
          s_d.a13 = REDUCED_PAGE ? req_addr_i[ddr_link_pkg::ROW_W-1] : 1'b0;
          s_d.wdata = req_wdata_i;
          s_d.wmask = req_wmask_i;
          if (req_op_i == ddr_link_pkg::CMD_WR) begin
            s_d.st = ddr_link_pkg::ST_WRITE;
            s_d.cnt = 4'(ddr_link_pkg::WRITE_LATENCY + 1);
          end else if (req_op_i == ddr_link_pkg::CMD_RD) begin
            s_d.st = ddr_link_pkg::ST_READ;
            s_d.cnt = 4'(CAS_LAT + 1);
          end
        end
      end
      ddr_link_pkg::ST_WRITE: begin
        // data shifted a quarter, strobe edges at the bit centres
        if (s_q.cnt == 4'h0) begin
          case (s_q.ph)
            2'h0: begin
              if (s_q.dq_oe) begin
                s_d.dq_oe = 1'b0;
                s_d.st = ddr_link_pkg::ST_IDLE;
              end else begin
                s_d.dq_oe = 1'b1;
                s_d.dq = s_q.wdata[W-1:0];
                s_d.dm = s_q.wmask[DQ_BYTES-1:0];
              end
            end
            2'h1: s_d.dqs = 1'b1;
            2'h2: begin
              s_d.dq = s_q.wdata[2*W-1:W];
              s_d.dm = s_q.wmask[2*DQ_BYTES-1:DQ_BYTES];
            end
            default: s_d.dqs = 1'b0;
          endcase
        end
      end
      ddr_link_pkg::ST_READ: begin
        // samples two flops behind the pins, a quarter after each link edge
        if (s_q.cnt == 4'h0 && s_q.ph == 2'h2) begin
          s_d.rdata[W-1:0] = s_q.s2;
          s_d.got0 = 1'b1;
        end
        if (s_q.got0 && s_q.ph == 2'h0) begin
          s_d.rdata[2*W-1:W] = s_q.s2;
          s_d.got0 = 1'b0;
          s_d.rsp_valid = 1'b1;
          s_d.st = ddr_link_pkg::ST_IDLE;
        end
      end
      default: s_d.st = ddr_link_pkg::ST_IDLE;
    endcase
    s_d.ready = (s_d.st == ddr_link_pkg::ST_IDLE) && (s_d.ph == 2'h1);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.ck = s_q.ck;
  assign link.cke = s_q.cke;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = s_q.cmd;
  assign link.ba = s_q.ba;
  assign link.addr = s_q.a;
  assign link.optional_row_bit_ball = s_q.a13;
  assign link.dm = s_q.dm;
  assign link.dq_ctl_o = s_q.dq;
  assign link.dq_ctl_oe = s_q.dq_oe;
  assign link.dqs_ctl_o = {DQ_BYTES{s_q.dqs}};
  assign link.dqs_ctl_oe = s_q.dq_oe;
  assign req_ready_o = s_q.ready;
  assign rsp_valid_o = s_q.rsp_valid;
  assign rsp_rdata_o = s_q.rdata;
endmodule // ddr_ctl_end

// ==== rtl/ddr_mem_end.sv ====
// memory end: samples commands on the link clock, keeps four banks,
// masked double-rate writes and edge-aligned double-rate reads
// assumes the controller end drives the link clock and every command pin
// How it works
// - commands sampled on rising link clock
// - data moves on both link clock edges
// - clock enable low disables inputs, drivers
// - enable drop picks self refresh or power-down
// - self refresh exit taken asynchronously
// - powered down: only clock enable heard
// - chip select high masks every command
// - four command pins decode one command
// - masked write bytes stay unchanged
// - masks sampled on both data edges
// - bank bits pick target bank
// - mode load: bank picks register, address value
// - activate gives row; read, write bit 10 autoprecharge
// - precharge bit 10 selects all banks
// - strobe edge-aligned on reads, centred writes
// - four independent banks work concurrently
// - x16 holds 8192 rows, 1024 columns
// - x32 holds 8192 rows, 512 columns
// - reduced page: 16384 rows, 256 columns
// - x16 has two byte lanes with masks
// - x32 has four numbered byte lanes
// - extra row bit only with reduced page
`timescale 1ns/100ps
module ddr_mem_end #(
  parameter int DQ_BYTES = 2,
  parameter bit REDUCED_PAGE = 1'b0,
  parameter int CAS_LAT = ddr_link_pkg::CAS_LATENCY,
  parameter int STORE_COL_BITS = 3
) (
  // link
  ddr_link_if.mem_end link,
  // reset
  input wire logic rst_n_i,
  // status
  output logic [ddr_link_pkg::NUM_BANKS-1:0] bank_open_o,
  output logic power_down_o,
  output logic self_refresh_o,
  output logic [ddr_link_pkg::NUM_BANKS-1:0][ddr_link_pkg::ADDR_W-1:0] mode_o
);
  localparam int W = 8 * DQ_BYTES;
  localparam int COLS = ddr_link_pkg::col_count(DQ_BYTES, REDUCED_PAGE);
  localparam int ROWS = ddr_link_pkg::row_count(REDUCED_PAGE);
  localparam int COL_W = $clog2(COLS);
  localparam int IDX_W = ddr_link_pkg::BA_W + STORE_COL_BITS;
  localparam int DEPTH = 1 << IDX_W;
  localparam int AP = ddr_link_pkg::AUTO_PRECHARGE_ADDRESS_BIT;

  if (!(DQ_BYTES == 2 || DQ_BYTES == 4) || (REDUCED_PAGE && DQ_BYTES != 4)
      || $clog2(ROWS) > ddr_link_pkg::ROW_W || STORE_COL_BITS < 1
      || STORE_COL_BITS > COL_W || CAS_LAT < 1 || CAS_LAT > 15) begin : g_bad_cfg
    $error("ddr_mem_end: unsupported configuration");
  end

  typedef struct packed {
    ddr_link_pkg::power_type pwr;
    logic pd;
    logic sr;
    logic [ddr_link_pkg::NUM_BANKS-1:0] open;
    logic [ddr_link_pkg::NUM_BANKS-1:0][ddr_link_pkg::ROW_W-1:0] row;
    logic [ddr_link_pkg::NUM_BANKS-1:0][ddr_link_pkg::ADDR_W-1:0] mode;
    logic [1:0] wr_stage;
    logic [ddr_link_pkg::BA_W-1:0] wr_bank;
    logic [COL_W-1:0] wr_col;
    logic wr_ap;
    logic [3:0] rd_cnt;
    logic [ddr_link_pkg::BA_W-1:0] rd_bank;
    logic [COL_W-1:0] rd_col;
    logic rd_ap;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic dq_oe;
    logic wake_s1;
    logic wake_s2;
    logic wake_ack;
    logic [DEPTH-1:0][W-1:0] mem;
  } mem_state_type;

  typedef struct packed {
    logic [W-1:0] beat0;
    logic [DQ_BYTES-1:0] mask0;
  } fall_cap_type;

  localparam mem_state_type RST = '{pwr: ddr_link_pkg::PWR_ON, default: '0};

  mem_state_type s_q;
  mem_state_type s_d;
  fall_cap_type f_q;
  logic wake_tog;
  ddr_link_pkg::cmd_type cmd;
  logic live;

  // storage keeps the low column bits of each bank; rows alias
  function automatic logic [IDX_W-1:0] idx_of(input logic [ddr_link_pkg::BA_W-1:0] b,
                                                input logic [COL_W-1:0] c);
    return {b, c[STORE_COL_BITS-1:0]};
  endfunction

  function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] data,
                                         input logic [DQ_BYTES-1:0] mask);
    logic [W-1:0] r;
    r = old;
    for (int b = 0; b < DQ_BYTES; b++) begin
      if (!mask[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // first write beat and its mask, taken on the falling link edge
  always_ff @(negedge link.ck or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f_q <= '0;
    end else begin
      f_q <= '{beat0: link.dq, mask0: link.dm};
    end
  end

  // enable rising edge caught without the link clock
  always_ff @(posedge link.cke or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_tog <= 1'b0;
    end else begin
      wake_tog <= ~wake_tog;
    end
  end

  always_comb begin
    s_d = s_q;
    cmd = ddr_link_pkg::decode_cmd({link.cs_n, link.ras_n, link.cas_n, link.we_n});
    live = (s_q.pwr == ddr_link_pkg::PWR_ON) && link.cke;
    s_d.wake_s1 = wake_tog;
    s_d.wake_s2 = s_q.wake_s1;
    s_d.wake_ack = s_q.wake_s2;
    s_d.dq_oe = 1'b0;

    case (s_q.pwr)
      ddr_link_pkg::PWR_ON: begin
        if (!link.cke) begin
          if (cmd == ddr_link_pkg::CMD_REF && !(|s_q.open)) begin
            s_d.pwr = ddr_link_pkg::PWR_SELF;
          end else if (|s_q.open) begin
            s_d.pwr = ddr_link_pkg::PWR_ACT_PD;
          end else begin
            s_d.pwr = ddr_link_pkg::PWR_PRE_PD;
          end
        end
      end
      ddr_link_pkg::PWR_PRE_PD, ddr_link_pkg::PWR_ACT_PD: begin
        if (link.cke) begin
          s_d.pwr = ddr_link_pkg::PWR_ON;
        end
      end
      ddr_link_pkg::PWR_SELF: begin
        if (s_q.wake_s2 != s_q.wake_ack) begin
          s_d.pwr = ddr_link_pkg::PWR_ON;
        end
      end
      default: s_d.pwr = ddr_link_pkg::PWR_ON;
    endcase
    s_d.pd = (s_d.pwr == ddr_link_pkg::PWR_PRE_PD) || (s_d.pwr == ddr_link_pkg::PWR_ACT_PD);
    s_d.sr = (s_d.pwr == ddr_link_pkg::PWR_SELF);

    // write: beat0 from the falling edge, beat1 and its mask sampled now
    s_d.wr_stage = {s_q.wr_stage[0], 1'b0};
    if (s_q.wr_stage[1] && live) begin
      s_d.mem[idx_of(s_q.wr_bank, s_q.wr_col)] = merge(s_q.mem[idx_of(s_q.wr_bank, s_q.wr_col)],
        f_q.beat0, f_q.mask0);
      s_d.mem[idx_of(s_q.wr_bank, COL_W'(s_q.wr_col + 1'b1))] = merge(
        s_q.mem[idx_of(s_q.wr_bank, COL_W'(s_q.wr_col + 1'b1))], link.dq, link.dm);
      if (s_q.wr_ap) begin
        s_d.open[s_q.wr_bank] = 1'b0;
      end
    end

    // read: data launched at the rising edge cas latency after the command
    if (s_q.rd_cnt != 4'h0) begin
      s_d.rd_cnt = s_q.rd_cnt - 4'h1;
      if (s_q.rd_cnt == 4'h1) begin
        s_d.rise = s_q.mem[idx_of(s_q.rd_bank, s_q.rd_col)];
        s_d.fall = s_q.mem[idx_of(s_q.rd_bank, COL_W'(s_q.rd_col + 1'b1))];
        s_d.dq_oe = link.cke;
        if (s_q.rd_ap) begin
          s_d.open[s_q.rd_bank] = 1'b0;
        end
      end
    end

    if (live) begin
      case (cmd)
        ddr_link_pkg::CMD_ACT: begin
          s_d.open[link.ba] = 1'b1;
          s_d.row[link.ba] = {REDUCED_PAGE ? link.optional_row_bit_ball : 1'b0, link.addr};
        end
        ddr_link_pkg::CMD_RD: begin
          if (s_q.open[link.ba] && s_q.rd_cnt == 4'h0) begin
            s_d.rd_cnt = 4'(CAS_LAT);
            s_d.rd_bank = link.ba;
            s_d.rd_col = link.addr[COL_W-1:0];
            s_d.rd_ap = link.addr[AP];
          end
        end
        ddr_link_pkg::CMD_WR: begin
          if (s_q.open[link.ba] && s_q.wr_stage == 2'h0) begin
            s_d.wr_stage[0] = 1'b1;
            s_d.wr_bank = link.ba;
            s_d.wr_col = link.addr[COL_W-1:0];
            s_d.wr_ap = link.addr[AP];
          end
        end
        ddr_link_pkg::CMD_PRE: begin
          if (link.addr[AP]) begin
            s_d.open = '0;
          end else begin
            s_d.open[link.ba] = 1'b0;
          end
        end
        ddr_link_pkg::CMD_LMR: s_d.mode[link.ba] = link.addr;
        default: ;
      endcase
    end
  end

  always_ff @(posedge link.ck or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // double-rate output: rising beat while ck high, falling beat while low
  assign link.dq_mem_o = link.ck ? s_q.rise : s_q.fall;
  assign link.dq_mem_oe = s_q.dq_oe;
  assign link.dqs_mem_o = {DQ_BYTES{link.ck & s_q.dq_oe}};
  assign link.dqs_mem_oe = s_q.dq_oe;
  assign bank_open_o = s_q.open;
  assign power_down_o = s_q.pd;
  assign self_refresh_o = s_q.sr;
  assign mode_o = s_q.mode;
endmodule // ddr_mem_end

// ==== sim/ddr_link_chk.sv ====
// checker on the link pins between the controller end and the memory end
// assumes clock_i runs the controller end and the link clock ck runs the memory end
`timescale 1ns/100ps
module ddr_link_chk #(
  parameter int DQ_BYTES = 2,
  parameter bit REDUCED_PAGE = 1'b0,
  parameter int CAS_LAT = 2
) (
  // clocks and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ck,
  // command and address
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic optional_row_bit_ball,
  // data drive
  input wire logic dq_ctl_oe,
  input wire logic dq_mem_oe,
  input wire logic [DQ_BYTES-1:0] dqs_mem_o
);
  logic [3:0] cmd;

  assign cmd = {cs_n, ras_n, cas_n, we_n};

  property p_pins_stable;
    @(posedge clock_i) disable iff (!rst_n_i) $rose(ck) |-> $stable({cmd, ba, addr, cke});
  endproperty
  a_pins_stable: assert property (p_pins_stable)
    else $error("command pins moved across link clock rise");

  property p_ck_div;
    @(posedge clock_i) disable iff (!rst_n_i) $fell(ck) |=> !ck ##1 ck [*2] ##1 !ck;
  endproperty
  a_ck_div: assert property (p_ck_div)
    else $error("link clock not a divide by four");

  property p_rd_latency;
    @(posedge ck) disable iff (!rst_n_i) $rose(dq_mem_oe) |-> $past(cmd, CAS_LAT + 1) == 4'h5;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("memory drove data without a selected read");

  property p_rd_burst;
    @(posedge ck) disable iff (!rst_n_i) $rose(dq_mem_oe) |=> !dq_mem_oe;
  endproperty
  a_rd_burst: assert property (p_rd_burst)
    else $error("read burst longer than one link clock");

  property p_dqs_read;
    @(negedge ck) disable iff (!rst_n_i) dqs_mem_o == {DQ_BYTES{dq_mem_oe}};
  endproperty
  a_dqs_read: assert property (p_dqs_read)
    else $error("read strobe not aligned to link clock");

  property p_wr_window;
    @(posedge ck) disable iff (!rst_n_i) cmd == 4'h4 |-> !dq_ctl_oe ##1 !dq_ctl_oe ##1 dq_ctl_oe ##1 !dq_ctl_oe;
  endproperty
  a_wr_window: assert property (p_wr_window)
    else $error("write data window misplaced");

  property p_bus_excl;
    @(posedge clock_i) disable iff (!rst_n_i) !(dq_mem_oe && dq_ctl_oe);
  endproperty
  a_bus_excl: assert property (p_bus_excl)
    else $error("both ends drive the data bus");

  property p_cke_gate;
    @(posedge ck) disable iff (!rst_n_i) (!cke && !dq_mem_oe) |=> !dq_mem_oe;
  endproperty
  a_cke_gate: assert property (p_cke_gate)
    else $error("memory drove data with clock enable low");

  property p_row_bit;
    @(posedge ck) disable iff (!rst_n_i) REDUCED_PAGE || !optional_row_bit_ball;
  endproperty
  a_row_bit: assert property (p_row_bit)
    else $error("extra row ball driven without reduced page");

  c_read: cover property (@(posedge ck) disable iff (!rst_n_i) $rose(dq_mem_oe));
  c_write: cover property (@(posedge ck) disable iff (!rst_n_i) cmd == 4'h4);
  c_cke_low: cover property (@(posedge ck) disable iff (!rst_n_i) $fell(cke));
endmodule // ddr_link_chk

// ==== sim/tb_top.sv ====
// bench: controller end and memory end joined by the link, driven from the user side
// assumes the controller end makes the link clock from clock_i
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clock_i;
  logic rst_n_i;
  logic req_valid_i;
  logic req_ready_o;
  ddr_link_pkg::cmd_type req_op_i;
  logic [1:0] req_bank_i;
  logic [13:0] req_addr_i;
  logic [31:0] req_wdata_i;
  logic [3:0] req_wmask_i;
  logic cke_i;
  logic cke_want;
  logic rsp_valid_o;
  logic [31:0] rsp_rdata_o;
  logic [3:0] bank_open_o;
  logic power_down_o;
  logic self_refresh_o;
  logic [3:0][12:0] mode_o;
  logic got;
  logic drove;
  logic [31:0] rdata;
  int errors;
  int check_count;

  ddr_link_if #(.DQ_BYTES(2)) link_bus ();

  ddr_ctl_end i_ddr_ctl_end (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_bus),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_bank_i(req_bank_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_wmask_i(req_wmask_i), .cke_i(cke_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o));

  ddr_mem_end i_ddr_mem_end (.link(link_bus), .rst_n_i(rst_n_i), .bank_open_o(bank_open_o),
    .power_down_o(power_down_o), .self_refresh_o(self_refresh_o), .mode_o(mode_o));

  ddr_link_chk #(.DQ_BYTES(2), .REDUCED_PAGE(1'b0), .CAS_LAT(ddr_link_pkg::CAS_LATENCY)) i_ddr_link_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ck(link_bus.ck), .cke(link_bus.cke), .cs_n(link_bus.cs_n),
    .ras_n(link_bus.ras_n), .cas_n(link_bus.cas_n), .we_n(link_bus.we_n), .ba(link_bus.ba),
    .addr(link_bus.addr), .optional_row_bit_ball(link_bus.optional_row_bit_ball),
    .dq_ctl_oe(link_bus.dq_ctl_oe), .dq_mem_oe(link_bus.dq_mem_oe), .dqs_mem_o(link_bus.dqs_mem_o));

  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic set_cke(input logic v);
    @(negedge clock_i);
    cke_want = v;
    cke_i = v;
  endtask

  // request held from a falling edge until the rising edge that sees ready
  task automatic req(input ddr_link_pkg::cmd_type op, input logic [1:0] b, input logic [13:0] a,
                     input logic [31:0] wd = 32'h0, input logic [3:0] wm = 4'h0);
    int n;
    @(negedge clock_i);
    req_op_i = op;
    req_bank_i = b;
    req_addr_i = a;
    req_wdata_i = wd;
    req_wmask_i = wm;
    cke_i = cke_want;
    req_valid_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 100) begin
      errors++;
      $display("MISMATCH req_ready expected 1 seen 0");
    end
    @(negedge clock_i);
    req_valid_i = 1'b0;
  endtask

  task automatic rd(input logic [1:0] b, input logic [13:0] a);
    req(ddr_link_pkg::CMD_RD, b, a);
    got = 1'b0;
    drove = 1'b0;
    for (int n = 0; n < 30 && !got; n++) begin
      @(negedge clock_i);
      if (link_bus.dq_mem_oe === 1'b1) drove = 1'b1;
      if (rsp_valid_o === 1'b1) begin
        got = 1'b1;
        rdata = rsp_rdata_o;
      end
    end
  endtask

  // byte-wise merge of old and new data under a write mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] m);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) r[8*i +: 8] = m[i] ? old[8*i +: 8] : nw[8*i +: 8];
    return r;
  endfunction

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  initial begin
    wait_cyc(5000);
    errors++;
    end_sim();
  end

  initial begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_op_i = ddr_link_pkg::CMD_NOP;
    req_bank_i = 2'h0;
    req_addr_i = 14'h0;
    req_wdata_i = 32'h0;
    req_wmask_i = 4'h0;
    cke_i = 1'b1;
    cke_want = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    `CHK("bank_open", 4'h0, bank_open_o)
    `CHK("cke", 1'b1, link_bus.cke)
    for (int b = 0; b < 4; b++) begin
      req(ddr_link_pkg::CMD_LMR, 2'(b), 14'h00a0 + 14'(b));
      wait_cyc(4);
      `CHK("mode", 13'h00a0 + 13'(b), mode_o[b])
    end
    req(ddr_link_pkg::CMD_DESEL, 2'h1, 14'h1fff);
    wait_cyc(4);
    `CHK("mode masked", 13'h00a1, mode_o[1])
    req(ddr_link_pkg::CMD_ACT, 2'h0, 14'h0123);
    req(ddr_link_pkg::CMD_ACT, 2'h2, 14'h0456);
    wait_cyc(4);
    `CHK("bank_open", 4'h5, bank_open_o)
    req(ddr_link_pkg::CMD_WR, 2'h0, 14'h0004, 32'h5a5a_c3c3, 4'h0);
    req(ddr_link_pkg::CMD_WR, 2'h0, 14'h0004, 32'h1111_2222, 4'h6);
    req(ddr_link_pkg::CMD_WR, 2'h2, 14'h0004, 32'h0f0f_7e7e, 4'h0);
    rd(2'h0, 14'h0004);
    `CHK("read bank0", merge(32'h5a5a_c3c3, 32'h1111_2222, 4'h6), rdata)
    `CHK("rsp_valid", 1'b1, got)
    `CHK("read drive", 1'b1, drove)
    rd(2'h2, 14'h0004);
    `CHK("read bank2", 32'h0f0f_7e7e, rdata)
    rd(2'h1, 14'h0004);
    `CHK("closed bank drive", 1'b0, drove)
    req(ddr_link_pkg::CMD_PRE, 2'h0, 14'h0000);
    wait_cyc(4);
    `CHK("bank_open", 4'h4, bank_open_o)
    req(ddr_link_pkg::CMD_ACT, 2'h3, 14'h0010);
    req(ddr_link_pkg::CMD_WR, 2'h3, 14'h0402, 32'h1234_5678, 4'h0);
    wait_cyc(24);
    `CHK("bank_open", 4'h4, bank_open_o)
    req(ddr_link_pkg::CMD_ACT, 2'h3, 14'h0010);
    rd(2'h3, 14'h0402);
    `CHK("read ap", 32'h1234_5678, rdata)
    `CHK("read ap valid", 1'b1, got)
    `CHK("bank_open", 4'h4, bank_open_o)
    req(ddr_link_pkg::CMD_PRE, 2'h1, 14'h0400);
    wait_cyc(4);
    `CHK("bank_open", 4'h0, bank_open_o)
    set_cke(1'b0);
    wait_cyc(12);
    `CHK("power_down", 1'b1, power_down_o)
    `CHK("self_refresh", 1'b0, self_refresh_o)
    req(ddr_link_pkg::CMD_ACT, 2'h1, 14'h0020);
    wait_cyc(8);
    `CHK("bank_open", 4'h0, bank_open_o)
    set_cke(1'b1);
    wait_cyc(12);
    `CHK("power_down", 1'b0, power_down_o)
    req(ddr_link_pkg::CMD_ACT, 2'h1, 14'h0020);
    set_cke(1'b0);
    wait_cyc(12);
    `CHK("power_down", 1'b1, power_down_o)
    `CHK("bank_open", 4'h2, bank_open_o)
    `CHK("self_refresh", 1'b0, self_refresh_o)
    set_cke(1'b1);
    wait_cyc(12);
    req(ddr_link_pkg::CMD_PRE, 2'h1, 14'h0400);
    wait_cyc(20);
    cke_want = 1'b0;
    req(ddr_link_pkg::CMD_REF, 2'h0, 14'h0000);
    wait_cyc(12);
    `CHK("self_refresh", 1'b1, self_refresh_o)
    set_cke(1'b1);
    wait_cyc(40);
    `CHK("self_refresh", 1'b0, self_refresh_o)
    req(ddr_link_pkg::CMD_ACT, 2'h2, 14'h2030);
    wait_cyc(8);
    `CHK("bank_open", 4'h4, bank_open_o)
    end_sim();
  end
endmodule // tb_top
